// >>> cad_action_decode.sv
// Purpose: decode later action fields of a classification lookup
// Assumes: action, layer and frame_start come from logic on this clock
// Notes:   one cycle from accepted action to result
//
// Our own choices: the address-and-strobe port and the register offsets.
`default_nettype none
`include "cad_consts.svh"
module cad_action_decode #(
  parameter int LOOKUPS = `CAD_LOOKUPS
)
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    frame_start,
  input  wire logic                    act_valid,
  input  wire cad_pkg::cad_action_s    action,
  input  wire logic [2:0]              lookup_idx,
  input  wire cad_pkg::cad_layer_s     layer,
  output logic                         res_valid,
  output cad_pkg::cad_result_s         result,
  output logic                         skip_lookups,
  input  wire logic [`CAD_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata
);
  cad_pkg::cad_state_e       state_reg;
  cad_pkg::cad_state_e       state_next;
  cad_pkg::cad_result_s      result_next;
  logic [`CAD_MID_W-1:0]     mid_reg;
  logic [4:0]                point_reg;
  logic                      short_reg;
  cad_pkg::cad_pipe_act_e    act_reg;
  logic [`CAD_TRI_W-1:0]     tri_sel_reg;
  logic [`CAD_CNT_W-1:0]     cnt_reg;
  logic                      accept;
  logic                      tri_cfg;
  logic                      key_forced;
  logic                      key_tri_idx;
  logic                      key_dst;
  logic                      key_done;
  logic [`CAD_PTR_W-1:0]     ptr_next;

  if (LOOKUPS < 1 || LOOKUPS > `CAD_TRI_W)
  begin : g_chk
    $error("LOOKUPS must be 1 to 8");
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // action acceptance and lookup sequencing
  // frame_start wins so a stale action cannot leak into a new frame
  assign accept       = act_valid && !frame_start && (state_reg == cad_pkg::CAD_ST_RUN);
  assign skip_lookups = (state_reg == cad_pkg::CAD_ST_DONE);
  // unused lookups read as plain triple vlan
  assign tri_cfg      = (int'(lookup_idx) < LOOKUPS) ? tri_sel_reg[lookup_idx] : 1'b0;

  // done state drops every later action until the next frame
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      cad_pkg::CAD_ST_RUN:
        if (!frame_start && accept && key_done)
          state_next = cad_pkg::CAD_ST_DONE;
      cad_pkg::CAD_ST_DONE:
        if (frame_start)
          state_next = cad_pkg::CAD_ST_RUN;
      default: state_next = cad_pkg::CAD_ST_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= cad_pkg::CAD_ST_RUN;
    else
      state_reg <= state_next;
  end
  ////////////////////////////////////////////////////////////////////////
  // submodules
  cad_key_sel u_key
  (
    .key_code    (action.next_key_format),
    .tri_cfg     (tri_cfg),
    .forced      (key_forced),
    .tri_indexed (key_tri_idx),
    .dst_key     (key_dst),
    .done        (key_done)
  );

  cad_ptr_adv #(.PTR_W (`CAD_PTR_W)) u_ptr
  (
    .fmt      (action.fmt),
    .skip_sel (action.layer_skip_select),
    .word_off (action.word_pointer_offset),
    .half_off (action.halfword_pointer_offset),
    .layer    (layer),
    .ptr_next (ptr_next)
  );
  ////////////////////////////////////////////////////////////////////////
  // next result
  always_comb
  begin
    result_next = '0;
    // only the full format carries match fields
    if (action.fmt == cad_pkg::CAD_FMT_FULL)
      result_next.match_identifier = (mid_reg & ~action.match_override_mask) |
        (action.match_identifier & action.match_override_mask);
    else
      result_next.match_identifier = mid_reg;
    result_next.pipe_point  = point_reg;
    result_next.point_short = short_reg;
    // forced point overrules anything set earlier
    if (action.pipe_force_code != `CAD_FORCE_NONE)
    begin
      if (action.fmt == cad_pkg::CAD_FMT_SHORT_STACK)
      begin
        result_next.pipe_point  = {2'h0, action.pipe_point_short};
        result_next.point_short = 1'b1;
      end
      else
      begin
        result_next.pipe_point  = action.pipe_point_full;
        result_next.point_short = 1'b0;
      end
    end
    result_next.pipe_action = cad_pkg::cad_force_action(action.pipe_force_code,
      action.pipe_action_select, act_reg);
    result_next.next_key_format = action.next_key_format;
    result_next.key_forced      = key_forced;
    result_next.tri_indexed     = key_tri_idx;
    result_next.dst_key         = key_dst;
    result_next.frame_ptr       = ptr_next;
  end
  ////////////////////////////////////////////////////////////////////////
  // accumulated per-frame state
  // cleared per frame; the pipeline state carries across lookups
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mid_reg   <= '0;
      point_reg <= '0;
      short_reg <= 1'b0;
      act_reg   <= cad_pkg::CAD_ACT_NONE;
    end
    else if (frame_start)
    begin
      mid_reg   <= '0;
      point_reg <= '0;
      short_reg <= 1'b0;
      act_reg   <= cad_pkg::CAD_ACT_NONE;
    end
    else if (accept)
    begin
      mid_reg   <= result_next.match_identifier;
      point_reg <= result_next.pipe_point;
      short_reg <= result_next.point_short;
      act_reg   <= result_next.pipe_action;
    end
  end

  // result registered so downstream sees stable data
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result    <= '0;
      res_valid <= 1'b0;
    end
    else
    begin
      res_valid <= accept;
      if (accept)
        result <= result_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tri_sel_reg <= '0;
    else if (reg_wr && reg_addr == `CAD_REG_CTRL)
      tri_sel_reg <= reg_wdata[`CAD_TRI_W-1:0];
  end

  // counter wraps; software reads deltas
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else if (accept)
      cnt_reg <= cnt_reg + 1'b1;
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else
    begin
      reg_rdata <= '0;
      if (reg_rd)
        case (reg_addr)
          `CAD_REG_CTRL: reg_rdata[`CAD_TRI_W-1:0] <= tri_sel_reg;
          `CAD_REG_STAT:
          begin
            reg_rdata[`CAD_MID_W-1:0]            <= mid_reg;
            reg_rdata[`CAD_STAT_PT +: 5]          <= point_reg;
            reg_rdata[`CAD_STAT_SHORT]           <= short_reg;
            reg_rdata[`CAD_STAT_ACT +: 3]         <= act_reg;
            reg_rdata[`CAD_STAT_SKIP]            <= skip_lookups;
          end
          `CAD_REG_CNT: reg_rdata[`CAD_CNT_W-1:0] <= cnt_reg;
          default: reg_rdata <= '0;
        endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_full_take;
    accept && action.fmt == cad_pkg::CAD_FMT_FULL;
  endsequence
  property p_mid_merge;
    s_full_take |=> result.match_identifier ==
      (($past(mid_reg) & ~$past(action.match_override_mask)) |
       ($past(action.match_identifier) & $past(action.match_override_mask)));
  endproperty
  a_mid_merge: assert property (p_mid_merge)
    else $error("match identifier merge wrong");
  property p_force_zero;
    accept && action.pipe_force_code == `CAD_FORCE_NONE |=>
      result.pipe_action == $past(act_reg) && result.pipe_point == $past(point_reg);
  endproperty
  a_force_zero: assert property (p_force_zero)
    else $error("zero force code changed pipeline state");
  property p_force_xtr;
    accept && action.pipe_force_code == `CAD_FORCE_XTR |=>
      result.pipe_action == cad_pkg::CAD_ACT_EXTRACTION;
  endproperty
  a_force_xtr: assert property (p_force_xtr)
    else $error("force code one not extraction");
  property p_force_inj;
    accept && action.pipe_force_code == `CAD_FORCE_INJ |=>
      result.pipe_action == ($past(action.pipe_action_select) ?
        cad_pkg::CAD_ACT_MASQ_INJ : cad_pkg::CAD_ACT_PLAIN_INJ);
  endproperty
  a_force_inj: assert property (p_force_inj)
    else $error("injection action wrong");
  property p_force_lbk;
    accept && action.pipe_force_code == `CAD_FORCE_LBK |=>
      result.pipe_action == ($past(action.pipe_action_select) ?
        cad_pkg::CAD_ACT_ASM_LOOP : cad_pkg::CAD_ACT_QUEUE_LOOP);
  endproperty
  a_force_lbk: assert property (p_force_lbk)
    else $error("loopback action wrong");
  property p_point_short;
    accept && action.pipe_force_code != `CAD_FORCE_NONE &&
      action.fmt == cad_pkg::CAD_FMT_SHORT_STACK |=>
      result.point_short && result.pipe_point[2:0] == $past(action.pipe_point_short);
  endproperty
  a_point_short: assert property (p_point_short)
    else $error("short pipeline point not applied");
  property p_point_full;
    accept && action.pipe_force_code != `CAD_FORCE_NONE &&
      action.fmt != cad_pkg::CAD_FMT_SHORT_STACK |=>
      !result.point_short && result.pipe_point == $past(action.pipe_point_full);
  endproperty
  a_point_full: assert property (p_point_full)
    else $error("full pipeline point not applied");
  property p_key_flags;
    accept |=> result.key_forced == ($past(action.next_key_format) != `CAD_KEY_DEF) &&
      result.dst_key == ($past(action.next_key_format) == `CAD_KEY_DST) &&
      result.tri_indexed == ($past(action.next_key_format) == `CAD_KEY_TRI && $past(tri_cfg));
  endproperty
  a_key_flags: assert property (p_key_flags)
    else $error("next key flags wrong");
  sequence s_done_hit;
    accept && action.next_key_format == `CAD_KEY_DONE;
  endsequence
  property p_done_skip;
    s_done_hit ##1 !frame_start |-> skip_lookups ##1 !res_valid;
  endproperty
  a_done_skip: assert property (p_done_skip)
    else $error("lookups not skipped after completion");
  property p_ptr_word;
    accept && action.fmt == cad_pkg::CAD_FMT_SHORT_STACK |=> result.frame_ptr ==
      `CAD_PTR_W'($past(layer.frame_ptr) + $past(action.word_pointer_offset) * 4);
  endproperty
  a_ptr_word: assert property (p_ptr_word)
    else $error("word offset advance wrong");
  property p_ptr_half;
    accept && action.fmt == cad_pkg::CAD_FMT_FULL |=> result.frame_ptr ==
      `CAD_PTR_W'($past(layer.frame_ptr) + $past(action.halfword_pointer_offset) * 2);
  endproperty
  a_ptr_half: assert property (p_ptr_half)
    else $error("halfword offset advance wrong");
  property p_ptr_order;
    accept && action.fmt == cad_pkg::CAD_FMT_CLASSIFY &&
      action.layer_skip_select == `CAD_SKIP_ETH && layer.frame_type == `CAD_FT_ETH |=>
      result.frame_ptr == `CAD_PTR_W'($past(layer.frame_ptr) + $past(layer.eth_len) +
        $past(action.halfword_pointer_offset) * 2);
  endproperty
  a_ptr_order: assert property (p_ptr_order)
    else $error("layer skip plus offset wrong");
endmodule : cad_action_decode
`default_nettype wire

// >>> cad_consts.svh
// Purpose: constants for the classifier action decoder
// Assumes: included by the package and the design modules
// Notes:   definitions only
`ifndef CAD_CONSTS_SVH
`define CAD_CONSTS_SVH
`define CAD_MID_W      12
`define CAD_PTR_W      8
`define CAD_ADDR_W     4
`define CAD_REG_CTRL   4'h0
`define CAD_REG_STAT   4'h4
`define CAD_REG_CNT    4'h8
`define CAD_TRI_W      8
`define CAD_CNT_W      16
`define CAD_STAT_PT    16
`define CAD_STAT_SHORT 21
`define CAD_STAT_ACT   24
`define CAD_STAT_SKIP  31
`define CAD_FORCE_NONE 2'h0
`define CAD_FORCE_XTR  2'h1
`define CAD_FORCE_INJ  2'h2
`define CAD_FORCE_LBK  2'h3
`define CAD_KEY_DEF    4'h0
`define CAD_KEY_TRI    4'h5
`define CAD_KEY_DST    4'h8
`define CAD_KEY_DONE   4'hF
`define CAD_SKIP_ETH   2'h1
`define CAD_SKIP_IPETH 2'h2
`define CAD_FT_ETH     2'h0
`define CAD_FT_CW      2'h1
`define CAD_W32_BYTES  4
`define CAD_W16_BYTES  2
`define CAD_LOOKUPS    4
`endif

// >>> cad_pkg.sv
// Purpose: types shared by the classifier action decoder
// Assumes: cad_consts.svh holds the identifier and pointer widths and the force codes
// Notes:   pipeline action decode lives here for the logic; the checks spell it out again
`default_nettype none
`include "cad_consts.svh"
package cad_pkg;
  typedef enum logic [1:0]
  {
    CAD_FMT_FULL        = 2'h0,
    CAD_FMT_CLASSIFY    = 2'h1,
    CAD_FMT_LABEL_STACK = 2'h2,
    CAD_FMT_SHORT_STACK = 2'h3
  } cad_format_e;

  typedef enum logic [2:0]
  {
    CAD_ACT_NONE        = 3'h0,
    CAD_ACT_EXTRACTION  = 3'h1,
    CAD_ACT_PLAIN_INJ   = 3'h2,
    CAD_ACT_MASQ_INJ    = 3'h3,
    CAD_ACT_QUEUE_LOOP  = 3'h4,
    CAD_ACT_ASM_LOOP    = 3'h5
  } cad_pipe_act_e;

  typedef enum logic [1:0]
  {
    CAD_ST_RUN  = 2'b01,
    CAD_ST_DONE = 2'b10
  } cad_state_e;

  typedef struct packed
  {
    cad_format_e           fmt;
    logic [`CAD_MID_W-1:0] match_override_mask;
    logic [`CAD_MID_W-1:0] match_identifier;
    logic [1:0]            pipe_force_code;
    logic                  pipe_action_select;
    logic [2:0]            pipe_point_short;
    logic [4:0]            pipe_point_full;
    logic [3:0]            next_key_format;
    logic [1:0]            word_pointer_offset;
    logic [4:0]            halfword_pointer_offset;
    logic [1:0]            layer_skip_select;
  } cad_action_s;

  typedef struct packed
  {
    logic [`CAD_PTR_W-1:0] frame_ptr;
    logic [1:0]            frame_type;
    logic [`CAD_PTR_W-1:0] eth_len;
    logic [`CAD_PTR_W-1:0] ip_len;
    logic                  ip_ver_ok;
  } cad_layer_s;

  typedef struct packed
  {
    logic [`CAD_MID_W-1:0] match_identifier;
    logic [4:0]            pipe_point;
    logic                  point_short;
    cad_pipe_act_e         pipe_action;
    logic [3:0]            next_key_format;
    logic                  key_forced;
    logic                  tri_indexed;
    logic                  dst_key;
    logic [`CAD_PTR_W-1:0] frame_ptr;
  } cad_result_s;

  // forced pipeline action; code zero keeps the current one
  function automatic cad_pipe_act_e cad_force_action(input logic [1:0]    code,
                                                     input logic          sel,
                                                     input cad_pipe_act_e cur);
    case (code)
      `CAD_FORCE_XTR: return CAD_ACT_EXTRACTION;
      `CAD_FORCE_INJ: return sel ? CAD_ACT_MASQ_INJ : CAD_ACT_PLAIN_INJ;
      `CAD_FORCE_LBK: return sel ? CAD_ACT_ASM_LOOP : CAD_ACT_QUEUE_LOOP;
      default:        return cur;
    endcase
  endfunction : cad_force_action
endpackage : cad_pkg
`default_nettype wire

// >>> cad_key_sel.sv
// Purpose: next key format decode for the following lookup
// Assumes: tri_cfg is the per-lookup triple vlan selection
// Notes:   purely combinational
`default_nettype none
`include "cad_consts.svh"
module cad_key_sel
(
  input  wire logic [3:0] key_code,
  input  wire logic       tri_cfg,
  output logic            forced,
  output logic            tri_indexed,
  output logic            dst_key,
  output logic            done
);
  // zero keeps the default key selection
  assign forced      = (key_code != `CAD_KEY_DEF);
  // code 5 picks the indexed variant from configuration
  assign tri_indexed = (key_code == `CAD_KEY_TRI) && tri_cfg;
  // code 8 swaps destination into the source key fields
  assign dst_key     = (key_code == `CAD_KEY_DST);
  assign done        = (key_code == `CAD_KEY_DONE);
endmodule : cad_key_sel
`default_nettype wire

// >>> cad_ptr_adv.sv
// Purpose: frame pointer advance by layer type and numeric offset
// Assumes: incoming pointer already stands past skipped reserved labels
// Notes:   combinational; sum wraps at the pointer width
`default_nettype none
`include "cad_consts.svh"
module cad_ptr_adv #(
  parameter int PTR_W = `CAD_PTR_W
)
(
  input  wire cad_pkg::cad_format_e fmt,
  input  wire logic [1:0]           skip_sel,
  input  wire logic [1:0]           word_off,
  input  wire logic [4:0]           half_off,
  input  wire cad_pkg::cad_layer_s  layer,
  output logic [PTR_W-1:0]          ptr_next
);
  logic [PTR_W-1:0] layer_bytes;
  logic [PTR_W-1:0] offs_bytes;

  if (PTR_W != `CAD_PTR_W)
  begin : g_chk
    $error("pointer width must match the layer struct");
  end

  // layer skip only exists in the label stack and classify formats
  always_comb
  begin
    layer_bytes = '0;
    if (fmt == cad_pkg::CAD_FMT_LABEL_STACK || fmt == cad_pkg::CAD_FMT_CLASSIFY)
    begin
      case (skip_sel)
        `CAD_SKIP_ETH:
          if (layer.frame_type == `CAD_FT_ETH)
            layer_bytes = layer.eth_len;
        `CAD_SKIP_IPETH:
          if (layer.frame_type == `CAD_FT_ETH)
            layer_bytes = PTR_W'(layer.eth_len + layer.ip_len);
          else if (layer.frame_type == `CAD_FT_CW && layer.ip_ver_ok)
            layer_bytes = layer.ip_len;
        default: layer_bytes = '0;  // none and reserved do not move
      endcase
    end
  end

  // offset times unit size; unit picked by format
  always_comb
  begin
    if (fmt == cad_pkg::CAD_FMT_SHORT_STACK)
      offs_bytes = PTR_W'(word_off * `CAD_W32_BYTES);
    else
      offs_bytes = PTR_W'(half_off * `CAD_W16_BYTES);
  end

  // layer move first, numeric offset after; skipped labels already in ptr
  assign ptr_next = PTR_W'(layer.frame_ptr + layer_bytes + offs_bytes);
endmodule : cad_ptr_adv
`default_nettype wire

// >>> cad_next_stage_model.sv
// Purpose: model of the next lookup stage that consumes decoder results
// Assumes: a result is taken only in its res_valid cycle
// Notes:   hands back the pointer for the next lookup, already past skipped labels
`default_nettype none
module cad_next_stage_model
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 frame_start,
  input  wire logic                 res_valid,
  input  wire cad_pkg::cad_result_s result,
  output logic [7:0]                ptr_fb
);
  timeunit 1ns;
  timeprecision 100ps;
  // restart per frame; the next lookup starts where this one ended, so any
  // skipped reserved labels are never counted again in an offset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ptr_fb <= 8'h00;
    else if (frame_start)
      ptr_fb <= 8'h00;
    else if (res_valid)
      ptr_fb <= result.frame_ptr;
  end
endmodule : cad_next_stage_model
`default_nettype wire

// >>> cad_action_decode_tb.sv
// Purpose: self-checking bench for the classifier action decoder
// Assumes: one result per accepted action, one cycle later
// Notes:   expected results are queued by the driver and popped by the monitor
`default_nettype none
`include "cad_consts.svh"
module cad_action_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clock, rst_n, frame_start, act_valid, res_valid, skip_lookups;
  logic                   reg_wr, reg_rd, sh_e, done_e;
  logic [2:0]             lookup_idx;
  logic [3:0]             reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, rnd;
  logic [7:0]             ptr_fb, ctrl_e;
  logic [11:0]            mid_e;
  logic [4:0]             pt_e;
  logic [15:0]            cnt_e;
  int                     num_errors, samples_checked, cycles;
  cad_pkg::cad_pipe_act_e act_e;
  cad_pkg::cad_action_s   action, a;
  cad_pkg::cad_layer_s    layer, l;
  cad_pkg::cad_result_s   result, w, exp_q[$];
  localparam int          ACT_W = $bits(cad_pkg::cad_action_s);

  cad_action_decode dut (.clock(clock), .rst_n(rst_n), .frame_start(frame_start),
    .act_valid(act_valid), .action(action), .lookup_idx(lookup_idx), .layer(layer),
    .res_valid(res_valid), .result(result), .skip_lookups(skip_lookups),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  cad_next_stage_model partner (.clock(clock), .rst_n(rst_n), .frame_start(frame_start),
    .res_valid(res_valid), .result(result), .ptr_fb(ptr_fb));

  ////////////////////////////////////////////////////////////////////////////////
  // clock at 4 ns
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
    samples_checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[ERR] %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  // drive one action and note what must come back; no release, so calls chain
  task automatic send(input cad_pkg::cad_action_s x, input cad_pkg::cad_layer_s y,
                      input logic [2:0] idx, input logic fs);
    cad_pkg::cad_result_s e;
    logic                 sh;
    logic [7:0]           lb;
    @(posedge clock);
    action <= x;
    layer <= y;
    lookup_idx <= idx;
    act_valid <= 1'b1;
    frame_start <= fs;
    sh = (x.fmt == cad_pkg::CAD_FMT_SHORT_STACK);
    if (fs)
    begin
      mid_e = 12'h000;
      pt_e = 5'h00;
      sh_e = 1'b0;
      act_e = cad_pkg::CAD_ACT_NONE;
      done_e = 1'b0;
    end
    else if (!done_e)
    begin
      if (x.fmt == cad_pkg::CAD_FMT_FULL)
        mid_e = (mid_e & ~x.match_override_mask) | (x.match_identifier & x.match_override_mask);
      if (x.pipe_force_code != 2'h0)
      begin
        pt_e = sh ? {2'h0, x.pipe_point_short} : x.pipe_point_full;
        sh_e = sh;
        case ({x.pipe_force_code, x.pipe_action_select})
          3'b010, 3'b011: act_e = cad_pkg::CAD_ACT_EXTRACTION;
          3'b100:         act_e = cad_pkg::CAD_ACT_PLAIN_INJ;
          3'b101:         act_e = cad_pkg::CAD_ACT_MASQ_INJ;
          3'b110:         act_e = cad_pkg::CAD_ACT_QUEUE_LOOP;
          default:        act_e = cad_pkg::CAD_ACT_ASM_LOOP;
        endcase
      end
      // layer move comes before the numeric offset
      lb = 8'h00;
      if (x.fmt inside {cad_pkg::CAD_FMT_CLASSIFY, cad_pkg::CAD_FMT_LABEL_STACK})
      begin
        if (x.layer_skip_select == 2'h1 && y.frame_type == 2'h0) lb = y.eth_len;
        if (x.layer_skip_select == 2'h2 && y.frame_type == 2'h0) lb = y.eth_len + y.ip_len;
        if (x.layer_skip_select == 2'h2 && y.frame_type == 2'h1 && y.ip_ver_ok) lb = y.ip_len;
      end
      e.frame_ptr = y.frame_ptr + lb + (sh ? {4'h0, x.word_pointer_offset, 2'b00}
                                          : {2'h0, x.halfword_pointer_offset, 1'b0});
      e.match_identifier = mid_e;
      e.pipe_point = pt_e;
      e.point_short = sh_e;
      e.pipe_action = act_e;
      e.next_key_format = x.next_key_format;
      e.key_forced = (x.next_key_format != 4'h0);
      e.tri_indexed = (x.next_key_format == 4'h5) && (idx < 3'h4) && ctrl_e[idx];
      e.dst_key = (x.next_key_format == 4'h8);
      exp_q.push_back(e);
      cnt_e++;
      done_e = (x.next_key_format == 4'hF);
    end
  endtask : send

  task automatic idle;
    @(posedge clock);
    act_valid <= 1'b0;
    frame_start <= 1'b0;
  endtask : idle

  task automatic reg_write(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] ad, input logic [31:0] want);
    @(posedge clock);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, want, "register read");
  endtask : reg_read

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: every result must match the oldest note
  // sampled mid-cycle, well clear of the edge that launches the result
  always @(negedge clock)
  begin
    if (res_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(64'h1, 64'h0, "result without action");
      else
      begin
        w = exp_q.pop_front();
        check(result.match_identifier, w.match_identifier, "match_identifier");
        check(result.pipe_point, w.pipe_point, "pipe point");
        check(result.point_short, w.point_short, "point format");
        check(result.pipe_action, w.pipe_action, "pipe action");
        check(result[14:8], w[14:8], "next key");
        check(result.frame_ptr, w.frame_ptr, "frame pointer");
      end
    end
  end

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, frame_start, act_valid, reg_wr, reg_rd, sh_e, done_e} = '0;
    {lookup_idx, reg_addr, reg_wdata, ctrl_e, mid_e, pt_e, cnt_e} = '0;
    {action, layer, num_errors, samples_checked, cycles} = '0;
    act_e = cad_pkg::CAD_ACT_NONE;
    rnd = 32'h0000_0046;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    reg_read(`CAD_REG_CTRL, 32'h0000_0000);
    reg_read(`CAD_REG_CNT, 32'h0000_0000);
    reg_write(`CAD_REG_CTRL, 32'hFFFF_FFA5);
    ctrl_e = 8'hA5;
    reg_write(`CAD_REG_STAT, 32'hFFFF_FFFF);
    reg_write(4'hC, 32'hFFFF_FFFF);
    reg_read(`CAD_REG_CTRL, 32'h0000_00A5);
    reg_read(4'hC, 32'h0000_0000);
    // random back-to-back actions, new frame every 40
    for (int i = 0; i < 200; i++)
    begin
      rnd = xs(rnd);
      a = ACT_W'({rnd, xs(rnd)});
      rnd = xs(rnd);
      l = rnd[26:0];
      l.frame_ptr = ptr_fb;
      if (a.next_key_format == 4'hF)
        a.next_key_format = 4'h5;
      send(a, l, rnd[31:29], (i % 40) == 0);
    end
    idle();
    repeat (3) idle();
    reg_read(`CAD_REG_STAT, {done_e, 4'h0, act_e, 2'b00, sh_e, pt_e, 4'h0, mid_e});
    reg_read(`CAD_REG_CNT, {16'h0000, cnt_e});
    // classification complete blocks later lookups until the next frame
    a.next_key_format = 4'hF;
    send(a, l, 3'h0, 1'b0);
    idle();
    idle();
    #1;
    check(skip_lookups, 64'h1, "skip not set");
    reg_read(`CAD_REG_STAT, {done_e, 4'h0, act_e, 2'b00, sh_e, pt_e, 4'h0, mid_e});
    send(a, l, 3'h1, 1'b0);
    idle();
    send(a, l, 3'h1, 1'b1);
    idle();
    idle();
    #1;
    check(skip_lookups, 64'h0, "skip not cleared");
    repeat (3) idle();
    check(exp_q.size(), 64'h0, "missing results");
    end_sim();
  end
endmodule : cad_action_decode_tb
`default_nettype wire
